// >>> logic/igc_top.sv
// file: global interrupt control registers with trap flags and polarity
//
// Overview of operation
// - control one bit 15 is writable; one disables nesting, zero allows it.
// - control one bit 6 sets on a divide-by-zero arithmetic trap.
// - control one bit 5 sets when a DMA controller error trap occurs.
// - control one bit 4 sets when a math error trap occurs.
// - control one bit 3 sets on an address error trap.
// - control one bit 2 sets on a stack error trap.
// - control one bit 1 sets on an oscillator failure trap.
// - control one bits 14..7 and 0 read zero, writes ignored.
// - control two bits 4..0 pick falling (1) or rising (0) edges.
// - alternate table select chooses which vector table is fetched.
// - low priority level bits are read-only while nesting is disabled.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module igc_top
  import igc_pkg::*;
(
  input  wire logic                      I_CLK,        // 40 MHz clock
  input  wire logic                      I_RSTN,       // sync reset, low
  input  wire logic [igc_pkg::ADDR_W-1:0] I_ADDR,      // register address
  input  wire logic [igc_pkg::DATA_W-1:0] I_WDATA,     // write data
  input  wire logic                      I_WR,         // write strobe
  input  wire logic                      I_RD,         // read strobe
  output logic      [igc_pkg::DATA_W-1:0] O_RDATA,     // read data
  input  wire igc_pkg::igc_trap_t        I_TRAP,       // trap pulses
  input  wire logic                      I_HOLD_ACT,   // hold instr active
  input  wire logic [igc_pkg::EXT_N-1:0] I_EXT_IRQ,    // external pins
  output logic      [igc_pkg::EXT_N-1:0] O_EXT_EVT,    // detected edges
  input  wire logic                      I_IPL_LOAD,   // core sets level
  input  wire logic [igc_pkg::IPL_W-1:0] I_IPL,        // level from core
  output logic      [igc_pkg::IPL_W-1:0] O_CPU_IPL,    // current level
  output logic                           O_NEST_DIS,   // nesting disabled
  input  wire logic                      I_VEC_REQ,    // vector fetch
  input  wire logic [igc_pkg::VEC_W-1:0] I_VEC_NUM,    // vector number
  output logic      [igc_pkg::VADR_W-1:0] O_VEC_ADDR,  // vector address
  output logic                           O_VEC_VALID,  // address valid
  output logic                           O_IRQ         // summary interrupt
);
  import igc_pkg::*;

  igc_bus_t          bus;

  logic              nest_dis_r;
  logic              nest_dis_nxt;
  igc_trap_t         trap_flag_r;
  igc_trap_t         trap_flag_nxt;
  logic              alt_vt_r;
  logic              alt_vt_nxt;
  logic              hold_r;
  logic              hold_nxt;
  logic [EXT_N-1:0]  pol_r;
  logic [EXT_N-1:0]  pol_nxt;
  logic [IPL_W-1:0]  ipl_r;
  logic [IPL_W-1:0]  ipl_nxt;
  logic [EVT_N-1:0]  evt_stat_r;
  logic [EVT_N-1:0]  evt_stat_nxt;
  logic [EVT_N-1:0]  evt_mask_r;
  logic [EVT_N-1:0]  evt_mask_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  logic [EXT_N-1:0]  ext_evt;
  logic [EVT_N-1:0]  evt_in;
  logic [DATA_W-1:0] ctrl_one_word;
  logic [DATA_W-1:0] ctrl_two_word;
  logic              wr_one;
  logic              wr_two;
  logic              wr_ipl;
  logic              wr_stat;
  logic              wr_mask;
  logic [DATA_W-1:0] ipl_word;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] mask_word;

  assign bus.wr    = I_WR;
  assign bus.rd    = I_RD;
  assign bus.addr  = I_ADDR;
  assign bus.wdata = I_WDATA;

  // external edge detection, one detector per input
  genvar g;
  generate
    for (g = 0; g < EXT_N; g++)
    begin : g_edge
      igc_edge_det u_edge
      (
        .i_clk  (I_CLK),
        .i_rstn (I_RSTN),
        .i_pin  (I_EXT_IRQ[g]),
        .i_fall (pol_r[g]),
        .o_evt  (ext_evt[g])
      );
    end
  endgenerate

  igc_vec_sel u_vec
  (
    .i_clk   (I_CLK),
    .i_rstn  (I_RSTN),
    .i_req   (I_VEC_REQ),
    .i_num   (I_VEC_NUM),
    .i_alt   (alt_vt_r),
    .o_addr  (O_VEC_ADDR),
    .o_valid (O_VEC_VALID)
  );

  // write decode
  always_comb
  begin
    wr_one  = bus.wr && (bus.addr == OFS_CTRL_ONE);
    wr_two  = bus.wr && (bus.addr == OFS_CTRL_TWO);
    wr_ipl  = bus.wr && (bus.addr == OFS_CPU_IPL);
    wr_stat = bus.wr && (bus.addr == OFS_EVT_STAT);
    wr_mask = bus.wr && (bus.addr == OFS_EVT_MASK);
  end

  // register images; unlisted positions stay zero
  always_comb
  begin
    ctrl_one_word                = RST_WORD;
    ctrl_one_word[BIT_NEST_DIS]  = nest_dis_r;
    ctrl_one_word[BIT_DIV0_FLAG] = trap_flag_r.div0;
    ctrl_one_word[BIT_DMA_FLAG]  = trap_flag_r.dma;
    ctrl_one_word[BIT_ARITH_FLG] = trap_flag_r.arith;
    ctrl_one_word[BIT_ADDR_FLAG] = trap_flag_r.addr;
    ctrl_one_word[BIT_STACK_FLG] = trap_flag_r.stack;
    ctrl_one_word[BIT_OSC_FLAG]  = trap_flag_r.osc;
    ctrl_two_word                = RST_WORD;
    ctrl_two_word[BIT_ALT_VT]    = alt_vt_r;
    ctrl_two_word[BIT_HOLD_ACT]  = hold_r;
    ctrl_two_word[BIT_POL_LO +: EXT_N] = pol_r;
    ipl_word                     = RST_WORD;
    ipl_word[IPL_W-1:0]          = ipl_r;
    stat_word                    = RST_WORD;
    stat_word[EVT_N-1:0]         = evt_stat_r;
    mask_word                    = RST_WORD;
    mask_word[EVT_N-1:0]         = evt_mask_r;
  end

  // control one: nesting disable and sticky trap flags
  always_comb
  begin
    nest_dis_nxt  = nest_dis_r;
    trap_flag_nxt = trap_flag_r;
    if (wr_one)
    begin
      nest_dis_nxt = bus.wdata[BIT_NEST_DIS];
      // writing zero clears; writing one leaves the flag alone
      trap_flag_nxt.div0  = trap_flag_r.div0  & bus.wdata[BIT_DIV0_FLAG];
      trap_flag_nxt.dma   = trap_flag_r.dma   & bus.wdata[BIT_DMA_FLAG];
      trap_flag_nxt.arith = trap_flag_r.arith & bus.wdata[BIT_ARITH_FLG];
      trap_flag_nxt.addr  = trap_flag_r.addr  & bus.wdata[BIT_ADDR_FLAG];
      trap_flag_nxt.stack = trap_flag_r.stack & bus.wdata[BIT_STACK_FLG];
      trap_flag_nxt.osc   = trap_flag_r.osc   & bus.wdata[BIT_OSC_FLAG];
    end
    // a trap in the clearing cycle wins over the clear
    trap_flag_nxt.div0  = trap_flag_nxt.div0  | I_TRAP.div0;
    trap_flag_nxt.dma   = trap_flag_nxt.dma   | I_TRAP.dma;
    trap_flag_nxt.arith = trap_flag_nxt.arith | I_TRAP.arith;
    trap_flag_nxt.addr  = trap_flag_nxt.addr  | I_TRAP.addr;
    trap_flag_nxt.stack = trap_flag_nxt.stack | I_TRAP.stack;
    trap_flag_nxt.osc   = trap_flag_nxt.osc   | I_TRAP.osc;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      nest_dis_r  <= 1'b0;
      trap_flag_r <= '0;
    end
    else
    begin
      nest_dis_r  <= nest_dis_nxt;
      trap_flag_r <= trap_flag_nxt;
    end
  end

  // control two: table select, hold status, edge polarity
  always_comb
  begin
    alt_vt_nxt = alt_vt_r;
    pol_nxt    = pol_r;
    hold_nxt   = I_HOLD_ACT;
    if (wr_two)
    begin
      alt_vt_nxt = bus.wdata[BIT_ALT_VT];
      pol_nxt    = bus.wdata[BIT_POL_LO +: EXT_N];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      alt_vt_r <= 1'b0;
      pol_r    <= RST_POL;
      hold_r   <= 1'b0;
    end
    else
    begin
      alt_vt_r <= alt_vt_nxt;
      pol_r    <= pol_nxt;
      hold_r   <= hold_nxt;
    end
  end

  // priority level: the core may always load it, software only
  // while nesting is enabled so a trap level cannot be undone
  always_comb
  begin
    ipl_nxt = ipl_r;
    if (wr_ipl && !nest_dis_r)
    begin
      ipl_nxt = bus.wdata[IPL_W-1:0];
    end
    if (I_IPL_LOAD)
    begin
      ipl_nxt = I_IPL;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      ipl_r <= RST_IPL;
    end
    else
    begin
      ipl_r <= ipl_nxt;
    end
  end

  // event sources in status order: traps low, external edges above
  always_comb
  begin
    evt_in                        = RST_EVT;
    evt_in[EVT_TRAP_LO +: TRAP_N] = I_TRAP;
    evt_in[EVT_EXT_LO +: EXT_N]   = ext_evt;
  end

  // event status: write one to clear; an event in the same cycle wins
  always_comb
  begin
    evt_stat_nxt = evt_stat_r;
    if (wr_stat)
    begin
      evt_stat_nxt = evt_stat_r & ~bus.wdata[EVT_N-1:0];
    end
    evt_stat_nxt = evt_stat_nxt | evt_in;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      evt_stat_r <= RST_EVT;
    end
    else
    begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  // event mask, same layout as the status
  always_comb
  begin
    evt_mask_nxt = evt_mask_r;
    if (wr_mask)
    begin
      evt_mask_nxt = bus.wdata[EVT_N-1:0];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      evt_mask_r <= RST_EVT;
    end
    else
    begin
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // summary built from next-state values so the output rises in the
  // same cycle as the status bit rather than one cycle after it
  always_comb
  begin
    irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  // read data stand for one cycle only; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = RST_WORD;
    if (bus.rd)
    begin
      case (bus.addr)
        OFS_CTRL_ONE: rdata_nxt = ctrl_one_word;
        OFS_CTRL_TWO: rdata_nxt = ctrl_two_word;
        OFS_CPU_IPL:  rdata_nxt = ipl_word;
        OFS_EVT_STAT: rdata_nxt = stat_word;
        OFS_EVT_MASK: rdata_nxt = mask_word;
        default:      rdata_nxt = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      rdata_r <= RST_WORD;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign O_RDATA    = rdata_r;
  assign O_IRQ      = irq_r;
  assign O_NEST_DIS = nest_dis_r;
  assign O_CPU_IPL  = ipl_r;
  assign O_EXT_EVT  = ext_evt;
endmodule : igc_top

// >>> logic/igc_pkg.sv
// package: constants and types for the global interrupt control block
package igc_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned EXT_N  = 5;
  localparam int unsigned TRAP_N = 6;
  localparam int unsigned EVT_N  = TRAP_N + EXT_N;
  localparam int unsigned IPL_W  = 3;
  localparam int unsigned VEC_W  = 7;
  localparam int unsigned VADR_W = 24;

  // register word addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CPU_IPL  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 4'h4;

  // control one field positions
  localparam int unsigned BIT_NEST_DIS  = 15;
  localparam int unsigned BIT_DIV0_FLAG = 6;
  localparam int unsigned BIT_DMA_FLAG  = 5;
  localparam int unsigned BIT_ARITH_FLG = 4;
  localparam int unsigned BIT_ADDR_FLAG = 3;
  localparam int unsigned BIT_STACK_FLG = 2;
  localparam int unsigned BIT_OSC_FLAG  = 1;

  // control two field positions
  localparam int unsigned BIT_ALT_VT    = 15;
  localparam int unsigned BIT_HOLD_ACT  = 14;
  localparam int unsigned BIT_POL_LO    = 0;

  // event status positions
  localparam int unsigned EVT_TRAP_LO = 0;
  localparam int unsigned EVT_EXT_LO  = TRAP_N;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD   = 16'h0000;
  localparam logic [IPL_W-1:0]  RST_IPL    = 3'h0;
  localparam logic [EXT_N-1:0]  RST_POL    = 5'h00;
  localparam logic [EVT_N-1:0]  RST_EVT    = 11'h000;

  // vector table bases, two bytes per vector
  localparam logic [VADR_W-1:0] VT_NORMAL_BASE = 24'h000004;
  localparam logic [VADR_W-1:0] VT_ALT_BASE    = 24'h000104;

  // trap events, one-cycle pulses from the core
  typedef struct packed {
    logic div0;
    logic dma;
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } igc_trap_t;

  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } igc_bus_t;

endpackage : igc_pkg

// >>> logic/igc_edge_det.sv
// file: edge detector for one external interrupt input
`timescale 1ns/1ps
module igc_edge_det
(
  input  wire logic i_clk,    // system clock
  input  wire logic i_rstn,   // synchronous reset, active low
  input  wire logic i_pin,    // external request level
  input  wire logic i_fall,   // 1 detects falling, 0 rising
  output logic      o_evt     // one-cycle edge pulse
);
  logic prev_r;
  logic prev_nxt;
  logic arm_r;
  logic arm_nxt;
  logic evt_r;
  logic evt_nxt;

  // the first cycle after reset only samples, so a pin already high
  // at release is not reported as an edge
  always_comb
  begin
    prev_nxt = i_pin;
    arm_nxt  = 1'b1;
    evt_nxt  = 1'b0;
    if (arm_r)
    begin
      evt_nxt = i_fall ? (prev_r & ~i_pin) : (~prev_r & i_pin);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      prev_r <= 1'b0;
      arm_r  <= 1'b0;
      evt_r  <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      arm_r  <= arm_nxt;
      evt_r  <= evt_nxt;
    end
  end

  assign o_evt = evt_r;
endmodule : igc_edge_det

// >>> logic/igc_vec_sel.sv
// file: vector address lookup in the normal or alternate table
`timescale 1ns/1ps
module igc_vec_sel
  import igc_pkg::*;
(
  input  wire logic              i_clk,   // system clock
  input  wire logic              i_rstn,  // synchronous reset, active low
  input  wire logic              i_req,   // vector fetch request pulse
  input  wire logic [VEC_W-1:0]  i_num,   // vector number
  input  wire logic              i_alt,   // alternate table select
  output logic      [VADR_W-1:0] o_addr,  // vector address
  output logic                   o_valid  // address valid pulse
);
  logic [VADR_W-1:0] addr_r;
  logic [VADR_W-1:0] addr_nxt;
  logic              valid_r;
  logic              valid_nxt;
  logic [VADR_W-1:0] base;
  logic [VADR_W-1:0] step;

  always_comb
  begin
    base      = i_alt ? VT_ALT_BASE : VT_NORMAL_BASE;
    step      = {{(VADR_W-VEC_W-1){1'b0}}, i_num, 1'b0};
    valid_nxt = i_req;
    addr_nxt  = addr_r;
    if (i_req)
    begin
      addr_nxt = base + step;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      addr_r  <= VT_NORMAL_BASE;
      valid_r <= 1'b0;
    end
    else
    begin
      addr_r  <= addr_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_addr  = addr_r;
  assign o_valid = valid_r;
endmodule : igc_vec_sel

// >>> bench/igc_core_mdl.sv
// model of the core trap logic and the external interrupt pins
`timescale 1ns/1ps
module igc_core_mdl
  import igc_pkg::*;
(
  input  wire logic        i_clk,    // system clock
  output igc_trap_t        o_trap,   // trap pulses
  output logic             o_hold,   // hold instruction level
  output logic [EXT_N-1:0] o_pin,    // external pin levels
  output logic             o_ipl_ld, // level load strobe
  output logic [IPL_W-1:0] o_ipl,    // level value
  output logic             o_vreq,   // vector fetch strobe
  output logic [VEC_W-1:0] o_vnum    // vector number
);
  initial
  begin
    o_trap   = '0;
    o_hold   = 1'b0;
    o_pin    = '0;
    o_ipl_ld = 1'b0;
    o_ipl    = '0;
    o_vreq   = 1'b0;
    o_vnum   = '0;
  end

  task automatic pulse_trap(input igc_trap_t t);
    @(posedge i_clk) o_trap <= t;
    @(posedge i_clk) o_trap <= '0;
    #1;
  endtask : pulse_trap

  task automatic set_hold(input logic h);
    @(posedge i_clk) o_hold <= h;
    #1;
  endtask : set_hold

  task automatic set_pins(input logic [EXT_N-1:0] v);
    @(posedge i_clk) o_pin <= v;
    #1;
  endtask : set_pins

  // released value lines carry the inverse so stale data never matches
  task automatic load_ipl(input logic [IPL_W-1:0] v);
    @(posedge i_clk)
    begin
      o_ipl_ld <= 1'b1;
      o_ipl    <= v;
    end
    @(posedge i_clk)
    begin
      o_ipl_ld <= 1'b0;
      o_ipl    <= ~v;
    end
    #1;
  endtask : load_ipl

  task automatic fetch(input logic [VEC_W-1:0] n);
    @(posedge i_clk)
    begin
      o_vreq <= 1'b1;
      o_vnum <= n;
    end
    @(posedge i_clk)
    begin
      o_vreq <= 1'b0;
      o_vnum <= ~n;
    end
    #1;
  endtask : fetch
endmodule : igc_core_mdl

// >>> bench/igc_chk.sv
// assertion checker for the global interrupt control block
`timescale 1ns/1ps
module igc_chk
  import igc_pkg::*;
(
  input wire logic              I_CLK,       // clock
  input wire logic              I_RSTN,      // reset, low
  input wire logic [ADDR_W-1:0] I_ADDR,      // address
  input wire logic [DATA_W-1:0] I_WDATA,     // write data
  input wire logic              I_WR,        // write strobe
  input wire logic              I_RD,        // read strobe
  input wire logic [DATA_W-1:0] O_RDATA,     // read data
  input wire igc_trap_t         I_TRAP,      // trap pulses
  input wire logic              I_HOLD_ACT,  // hold active
  input wire logic [EXT_N-1:0]  I_EXT_IRQ,   // pins
  input wire logic [EXT_N-1:0]  O_EXT_EVT,   // edge pulses
  input wire logic              I_IPL_LOAD,  // level load
  input wire logic [IPL_W-1:0]  I_IPL,       // level in
  input wire logic [IPL_W-1:0]  O_CPU_IPL,   // level out
  input wire logic              O_NEST_DIS,  // nesting off
  input wire logic              I_VEC_REQ,   // vector fetch
  input wire logic [VEC_W-1:0]  I_VEC_NUM,   // vector number
  input wire logic [VADR_W-1:0] O_VEC_ADDR,  // vector address
  input wire logic              O_VEC_VALID, // address valid
  input wire logic              O_IRQ        // interrupt
);
  logic             nest_r;
  logic             alt_r;
  logic             hold_r;
  logic [5:0]       flag_r;
  logic [EXT_N-1:0] pol_r;
  logic [EXT_N-1:0] pin_r;
  logic [EXT_N-1:0] edge_w;
  logic             w1;
  logic             w2;

  assign w1     = I_WR && I_ADDR == OFS_CTRL_ONE;
  assign w2     = I_WR && I_ADDR == OFS_CTRL_TWO;
  assign edge_w = (I_EXT_IRQ ^ pin_r) & (I_EXT_IRQ ^ pol_r);

  // pins sampled through reset so release never looks like an edge
  always_ff @(posedge I_CLK)
  begin
    pin_r  <= I_EXT_IRQ;
    hold_r <= I_HOLD_ACT;
    if (!I_RSTN)
    begin
      nest_r <= 1'b0;
      alt_r  <= 1'b0;
      flag_r <= '0;
      pol_r  <= '0;
    end
    else
    begin
      flag_r <= I_TRAP | (flag_r & (w1 ? I_WDATA[6:1] : 6'h3f));
      if (w1)
        nest_r <= I_WDATA[15];
      if (w2)
      begin
        alt_r <= I_WDATA[15];
        pol_r <= I_WDATA[4:0];
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  nest_follow_a: assert property (
    w1 |=> O_NEST_DIS == $past(I_WDATA[15]))
    else $error("nesting disable does not follow the write");
  one_read_a: assert property (
    I_RD && I_ADDR == OFS_CTRL_ONE |=>
    O_RDATA == $past({nest_r, 8'h00, flag_r, 1'b0}))
    else $error("control one read value wrong");
  one_rsvd_a: assert property (
    I_RD && I_ADDR == OFS_CTRL_ONE |=> (O_RDATA & 16'h7f81) == 16'h0000)
    else $error("reserved control one bits read as one");
  two_read_a: assert property (
    I_RD && I_ADDR == OFS_CTRL_TWO |=>
    O_RDATA == $past({alt_r, hold_r, 9'h000, pol_r}))
    else $error("control two read value wrong");
  edge_pulse_a: assert property (
    1'b1 |=> O_EXT_EVT == $past(edge_w))
    else $error("edge pulse does not match polarity");
  vec_addr_a: assert property (I_VEC_REQ |=> O_VEC_VALID &&
    O_VEC_ADDR == ($past(alt_r) ? VT_ALT_BASE : VT_NORMAL_BASE) +
    {$past(I_VEC_NUM), 1'b0})
    else $error("vector address wrong");
  ipl_lock_a: assert property (
    I_WR && I_ADDR == OFS_CPU_IPL && O_NEST_DIS && !I_IPL_LOAD |=>
    $stable(O_CPU_IPL))
    else $error("priority level written while locked");
  rdata_idle_a: assert property (!I_RD |=> O_RDATA == '0)
    else $error("read data not zero outside a read");
  valid_pulse_a: assert property (!I_VEC_REQ |=> !O_VEC_VALID)
    else $error("vector valid without a fetch");

  trap_c: cover property (I_TRAP != '0 ##1 I_RD && I_ADDR == OFS_CTRL_ONE);
  alt_c: cover property (I_VEC_REQ && alt_r);
  fall_c: cover property (O_EXT_EVT != '0 && pol_r != '0);
endmodule : igc_chk

bind igc_top igc_chk i_igc_chk (.*);

// >>> bench/tb.sv
// self-checking testbench for the global interrupt control block
`timescale 1ns/1ps
module tb;
  import igc_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  igc_trap_t         trap;
  logic              hold, ipl_ld, vreq, nest, vvalid, irq;
  logic [EXT_N-1:0]  pin, evt;
  logic [IPL_W-1:0]  cpu_priority_level, cpu_ipl;
  logic [VEC_W-1:0]  vnum;
  logic [VADR_W-1:0] vaddr;
  int                fail_count = 0;
  int                compares = 0;
  int                cyc = 0;

  always #12.5 clk = ~clk;

  igc_top i_igc_top (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TRAP(trap),
    .I_HOLD_ACT(hold), .I_EXT_IRQ(pin), .O_EXT_EVT(evt),
    .I_IPL_LOAD(ipl_ld), .I_IPL(cpu_priority_level), .O_CPU_IPL(cpu_ipl),
    .O_NEST_DIS(nest), .I_VEC_REQ(vreq), .I_VEC_NUM(vnum),
    .O_VEC_ADDR(vaddr), .O_VEC_VALID(vvalid), .O_IRQ(irq));

  igc_core_mdl i_igc_core_mdl (.i_clk(clk), .o_trap(trap), .o_hold(hold),
    .o_pin(pin), .o_ipl_ld(ipl_ld), .o_ipl(cpu_priority_level), .o_vreq(vreq),
    .o_vnum(vnum));

  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // a hang costs one mismatch and ends the run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk)
    begin
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
    end
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk)
    begin
      rd   <= 1'b1;
      addr <= a;
    end
    @(posedge clk) rd <= 1'b0;
    #1;
    check(24'(rdata), 24'(exp));
  endtask : rd_chk

  task automatic t_regs();
    rd_chk(OFS_CTRL_ONE, 16'h0000);
    rd_chk(OFS_CTRL_TWO, 16'h0000);
    rd_chk(4'h7, 16'h0000);
    wr_reg(OFS_CTRL_ONE, 16'hffff);
    check(24'(nest), 24'h1);
    rd_chk(OFS_CTRL_ONE, 16'h8000);
    wr_reg(OFS_CPU_IPL, 16'h0005);
    rd_chk(OFS_CPU_IPL, 16'h0000);
    i_igc_core_mdl.load_ipl(3'h6);
    check(24'(cpu_ipl), 24'h6);
    wr_reg(OFS_CTRL_ONE, 16'h0000);
    check(24'(nest), 24'h0);
    wr_reg(OFS_CPU_IPL, 16'h0005);
    rd_chk(OFS_CPU_IPL, 16'h0005);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_traps();
    logic [15:0] f;
    f = '0;
    wr_reg(OFS_EVT_MASK, 16'h0001);
    for (int i = 0; i < TRAP_N; i++)
    begin
      i_igc_core_mdl.pulse_trap(igc_trap_t'(6'h01 << i));
      f[i+1] = 1'b1;
      rd_chk(OFS_CTRL_ONE, f);
    end
    check(24'(irq), 24'h1);
    rd_chk(OFS_EVT_STAT, 16'h003f);
    wr_reg(OFS_EVT_STAT, 16'h0001);
    @(posedge clk);
    #1;
    check(24'(irq), 24'h0);
    wr_reg(OFS_EVT_MASK, 16'h003e);
    @(posedge clk);
    #1;
    check(24'(irq), 24'h1);
    rd_chk(OFS_EVT_MASK, 16'h003e);
    wr_reg(OFS_EVT_STAT, 16'hffff);
    @(posedge clk);
    #1;
    check(24'(irq), 24'h0);
    wr_reg(OFS_CTRL_ONE, 16'h7f7f);
    rd_chk(OFS_CTRL_ONE, 16'h007e);
    // a trap landing on the clearing write must survive it
    fork
      i_igc_core_mdl.pulse_trap(igc_trap_t'(6'h01));
      wr_reg(OFS_CTRL_ONE, 16'h0000);
    join
    rd_chk(OFS_CTRL_ONE, 16'h0002);
    wr_reg(OFS_CTRL_ONE, 16'h0000);
    rd_chk(OFS_CTRL_ONE, 16'h0000);
    $display("t_traps done");
  endtask : t_traps

  task automatic t_ext();
    logic [EXT_N-1:0] v;
    logic             pol;
    v = '0;
    for (int p = 0; p < 3; p++)
    begin
      pol = (p != 0);
      wr_reg(OFS_CTRL_TWO, pol ? 16'h001f : 16'h0000);
      for (int i = 0; i < EXT_N; i++)
      begin
        v[i] = ~v[i];
        i_igc_core_mdl.set_pins(v);
        @(posedge clk);
        #1;
        check(24'(evt), (v[i] != pol) ? 24'(1 << i) : 24'h0);
      end
    end
    rd_chk(OFS_CTRL_TWO, 16'h001f);
    rd_chk(OFS_EVT_STAT, 16'h07c1);
    $display("t_ext done");
  endtask : t_ext

  task automatic t_hold_vec();
    wr_reg(OFS_CTRL_TWO, 16'h8000);
    i_igc_core_mdl.set_hold(1'b1);
    rd_chk(OFS_CTRL_TWO, 16'hc000);
    i_igc_core_mdl.fetch(7'h02);
    check(24'(vvalid), 24'h1);
    check(vaddr, VT_ALT_BASE + 24'h4);
    i_igc_core_mdl.set_hold(1'b0);
    wr_reg(OFS_CTRL_TWO, 16'h4000);
    rd_chk(OFS_CTRL_TWO, 16'h0000);
    i_igc_core_mdl.fetch(7'h02);
    check(vaddr, VT_NORMAL_BASE + 24'h4);
    $display("t_hold_vec done");
  endtask : t_hold_vec

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_traps();
    t_ext();
    t_hold_vec();
    finish_test();
  end
endmodule : tb
